/* rtl/ddrop_port.sv */
// constants and top module of the dual channel ddr sample output port
//
// Function
// - each 16-bit sample leaves on eight pairs, two bits per pair per clock
// - odd bit of every pair is driven first, then the even bit
// - forwarded clock runs at exactly the sampling clock frequency
// - exactly one whole sample word per channel in each forwarded clock cycle
package ddrop_pkg;
  localparam int unsigned SAMPLE_W   = 16;
  localparam int unsigned PAIR_N     = 8;
  localparam int unsigned FIFO_W     = 32;
  localparam int unsigned FIFO_DEPTH = 8;
endpackage : ddrop_pkg

`timescale 1ns/1ps
`default_nettype none

module ddrop_port (
  // clock and reset
  input  wire logic                           clk_in,
  input  wire logic                           rst_in,
  // sampling clock pin, asynchronous to clk_in
  input  wire logic                           sample_clock_in,
  // sample words from the converter core
  input  wire logic                           sample_valid_in,
  input  wire logic [ddrop_pkg::SAMPLE_W-1:0] chan_a_sample_in,
  input  wire logic [ddrop_pkg::SAMPLE_W-1:0] chan_b_sample_in,
  output logic                                sample_ready_out,
  // ddr link
  output logic                                forwarded_sample_clock_out,
  output logic [ddrop_pkg::PAIR_N-1:0]        chan_a_ddr_pairs_out,
  output logic [ddrop_pkg::PAIR_N-1:0]        chan_b_ddr_pairs_out,
  // status
  output logic                                underrun_out
);
  import ddrop_pkg::*;

  // s1 to s3 form the synchroniser and edge detector on the sampling clock pin
  typedef struct packed {
    logic                s1;
    logic                s2;
    logic                s3;
    logic [FIFO_W-1:0]   word;
    logic                clk_o;
    logic [PAIR_N-1:0]   a_pairs;
    logic [PAIR_N-1:0]   b_pairs;
    logic                underrun;
  } ddrop_port_s;

  ddrop_port_s       q;
  ddrop_port_s       d;
  logic              rise;
  logic              fall;
  logic              fifo_valid;
  logic [FIFO_W-1:0] fifo_data;
  logic [FIFO_W-1:0] nxt_word;
  logic [PAIR_N-1:0] odd_nxt_a;
  logic [PAIR_N-1:0] odd_nxt_b;
  logic [PAIR_N-1:0] odd_cur_a;
  logic [PAIR_N-1:0] odd_cur_b;
  logic [PAIR_N-1:0] even_cur_a;
  logic [PAIR_N-1:0] even_cur_b;

  // edges are found from the second and third stages only
  // limitation: each sampling clock phase must last at least one clk_in cycle or edges are missed
  assign rise = q.s2 & ~q.s3;
  assign fall = ~q.s2 & q.s3;

  // on an empty buffer the last word is repeated so the link never stalls
  assign nxt_word = fifo_valid ? fifo_data : q.word;

  // a pop is asked on every detected rising edge; an empty buffer simply ignores it
  ddrop_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (sample_valid_in),
    .in_data_in    ({chan_a_sample_in, chan_b_sample_in}),
    .in_ready_out  (sample_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (rise)
  );

  // pair k carries bits 2k+1 and 2k of each channel word
  for (genvar k = 0; k < PAIR_N; k++) begin : g_pair
    assign odd_nxt_a[k]  = nxt_word[SAMPLE_W + 2*k + 1];
    assign odd_nxt_b[k]  = nxt_word[2*k + 1];
    assign odd_cur_a[k]  = q.word[SAMPLE_W + 2*k + 1];
    assign odd_cur_b[k]  = q.word[2*k + 1];
    assign even_cur_a[k] = q.word[SAMPLE_W + 2*k];
    assign even_cur_b[k] = q.word[2*k];
  end

  always_comb begin
    d    = q;
    d.s1 = sample_clock_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (rise) begin
      d.word     = nxt_word;
      d.underrun = ~fifo_valid;
      d.clk_o    = 1'b1;
      d.a_pairs  = odd_nxt_a;
      d.b_pairs  = odd_nxt_b;
    end else if (fall) begin
      d.clk_o    = 1'b0;
      d.a_pairs  = even_cur_a;
      d.b_pairs  = even_cur_b;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign forwarded_sample_clock_out = q.clk_o;
  assign chan_a_ddr_pairs_out       = q.a_pairs;
  assign chan_b_ddr_pairs_out       = q.b_pairs;
  assign underrun_out               = q.underrun;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  property p_clk_rise;
    rise |=> forwarded_sample_clock_out ##1 $stable(forwarded_sample_clock_out) or fall;
  endproperty
  a_clk_rise: assert property (p_clk_rise)
    else $error("output clock missed a rising sample edge");

  property p_clk_fall;
    fall |=> !forwarded_sample_clock_out;
  endproperty
  a_clk_fall: assert property (p_clk_fall)
    else $error("output clock missed a falling sample edge");

  property p_odd_first;
    $rose(forwarded_sample_clock_out) |-> chan_a_ddr_pairs_out == odd_cur_a
      && chan_b_ddr_pairs_out == odd_cur_b;
  endproperty
  a_odd_first: assert property (p_odd_first)
    else $error("odd bits not on pairs in high phase");

  property p_even_second;
    $fell(forwarded_sample_clock_out) |-> chan_a_ddr_pairs_out == even_cur_a
      && chan_b_ddr_pairs_out == even_cur_b;
  endproperty
  a_even_second: assert property (p_even_second)
    else $error("even bits not on pairs in low phase");

  property p_word_held;
    (forwarded_sample_clock_out && !$rose(forwarded_sample_clock_out)) |-> $stable(q.word);
  endproperty
  a_word_held: assert property (p_word_held)
    else $error("word changed inside one output clock");

  property p_one_word;
    $rose(forwarded_sample_clock_out) && !underrun_out |-> q.word == $past(fifo_data);
  endproperty
  a_one_word: assert property (p_one_word)
    else $error("output word is not the buffer head");

  property p_aligned;
    ($changed(chan_a_ddr_pairs_out) || $changed(chan_b_ddr_pairs_out))
      |-> $changed(forwarded_sample_clock_out);
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("pairs changed away from a clock edge");

  property p_clk_tracks;
    forwarded_sample_clock_out == q.s3;
  endproperty
  a_clk_tracks: assert property (p_clk_tracks)
    else $error("output clock lost step with the sampling clock");

  property p_under_flag;
    rise |=> underrun_out == !$past(fifo_valid);
  endproperty
  a_under_flag: assert property (p_under_flag)
    else $error("underrun flag does not match the buffer at the rising edge");

  property p_repeat_word;
    rise && !fifo_valid |=> $stable(q.word);
  endproperty
  a_repeat_word: assert property (p_repeat_word)
    else $error("empty buffer did not repeat the previous word");

  property p_rise_loads;
    rise |=> chan_a_ddr_pairs_out == $past(odd_nxt_a)
      && chan_b_ddr_pairs_out == $past(odd_nxt_b);
  endproperty
  a_rise_loads: assert property (p_rise_loads)
    else $error("rising edge did not load the odd bits of the next word");

  property p_pairs_high;
    forwarded_sample_clock_out && !$rose(forwarded_sample_clock_out)
      |-> $stable(chan_a_ddr_pairs_out) && $stable(chan_b_ddr_pairs_out);
  endproperty
  a_pairs_high: assert property (p_pairs_high)
    else $error("pairs moved inside the high phase");

  property p_pairs_low;
    !forwarded_sample_clock_out && !$fell(forwarded_sample_clock_out)
      |-> $stable(chan_a_ddr_pairs_out) && $stable(chan_b_ddr_pairs_out);
  endproperty
  a_pairs_low: assert property (p_pairs_low)
    else $error("pairs moved inside the low phase");

  property p_word_low_held;
    !forwarded_sample_clock_out |-> $stable(q.word);
  endproperty
  a_word_low_held: assert property (p_word_low_held)
    else $error("word changed inside the low phase");

endmodule : ddrop_port

`default_nettype wire

/* rtl/ddrop_fifo.sv */
// parameterised valid/ready fifo buffering sample words ahead of the ddr output stage
`timescale 1ns/1ps
`default_nettype none

module ddrop_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  // depth must be a power of two: pointers wrap by overflow
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic                        rdy;
  } ddrop_fifo_s;

  ddrop_fifo_s q;
  ddrop_fifo_s d;
  logic        push;
  logic        pop;

  always_comb begin
    d    = q;
    push = in_valid_in & q.rdy;
    pop  = out_ready_in & (q.cnt != '0);
    if (push) begin
      d.mem[q.wr] = in_data_in;
      d.wr        = q.wr + AW'(1);
    end
    if (pop) begin
      d.rd = q.rd + AW'(1);
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
    // ready is registered, so a pop frees a slot one cycle later
    d.rdy = (d.cnt != CW'(DEPTH));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q     <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign in_ready_out  = q.rdy;
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out  = q.mem[q.rd];

endmodule : ddrop_fifo

`default_nettype wire

/* sim/ddrop_rx_model.sv */
// receiver model that captures and de-interleaves the ddr sample words
`timescale 1ns/1ps
`default_nettype none
module ddrop_rx_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // ddr link
  input  wire logic        fclk_in,
  input  wire logic [7:0]  pairs_a_in,
  input  wire logic [7:0]  pairs_b_in,
  // reassembled words
  output logic             strobe_out,
  output logic [15:0]      word_a_out,
  output logic [15:0]      word_b_out
);
  logic       fclk_q;
  logic       odd_ok_q;
  logic [7:0] pa_q;
  logic [7:0] pb_q;
  logic [7:0] oa_q;
  logic [7:0] ob_q;
  function automatic logic [15:0] weave(input logic [7:0] odd, input logic [7:0] even);
    for (int k = 0; k < 8; k++) begin
      weave[2*k+1] = odd[k];
      weave[2*k]   = even[k];
    end
  endfunction : weave
  // pairs are taken as they stood just before the clock edge, as a real flop would
  always_ff @(posedge clk_in) begin
    fclk_q     <= fclk_in;
    pa_q       <= pairs_a_in;
    pb_q       <= pairs_b_in;
    strobe_out <= 1'b0;
    if (rst_in) begin
      odd_ok_q <= 1'b0;
    end else if (fclk_q && !fclk_in) begin
      oa_q     <= pa_q;
      ob_q     <= pb_q;
      odd_ok_q <= 1'b1;
    end else if (!fclk_q && fclk_in && odd_ok_q) begin
      word_a_out <= weave(oa_q, pa_q);
      word_b_out <= weave(ob_q, pb_q);
      strobe_out <= 1'b1;
    end
  end
endmodule : ddrop_rx_model
`default_nettype wire

/* sim/test_ddrop_port.sv */
// self-checking bench for the ddr sample output port
`timescale 1ns/1ps
`default_nettype none
module test_ddrop_port;
  import ddrop_pkg::*;
  logic              clk = 1'b0, rst = 1'b1, sclk = 1'b0, run = 1'b0, valid = 1'b0;
  logic [SAMPLE_W-1:0] a = '0, b = '0, ra, rb;
  logic              ready, fclk, under, strobe;
  logic [PAIR_N-1:0] pa, pb;
  int                mismatches = 0, n_checks = 0;
  always #10 clk = ~clk;
  // sampling clock, parked low while the link is stalled so the buffer can fill
  initial begin
    #7;
    forever begin
      #80;
      sclk = run ? ~sclk : 1'b0;
    end
  end
  ddrop_port ddrop_port_inst (.clk_in(clk), .rst_in(rst), .sample_clock_in(sclk),
    .sample_valid_in(valid), .chan_a_sample_in(a), .chan_b_sample_in(b),
    .sample_ready_out(ready), .forwarded_sample_clock_out(fclk),
    .chan_a_ddr_pairs_out(pa), .chan_b_ddr_pairs_out(pb), .underrun_out(under));
  ddrop_rx_model ddrop_rx_model_inst (.clk_in(clk), .rst_in(rst), .fclk_in(fclk),
    .pairs_a_in(pa), .pairs_b_in(pb), .strobe_out(strobe), .word_a_out(ra), .word_b_out(rb));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  task automatic get_word;
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (strobe !== 1'b1 && n < 40);
    // a receiver that never strobes counts as a mismatch rather than hanging the run
    if (strobe !== 1'b1) begin
      mismatches++;
    end
  endtask : get_word
  // fill until refused, hold a ninth word while refused, then drain past empty
  task automatic t_stream;
    int          n = 0;
    logic [31:0] exp_w;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      check("ready", ready, 1);
      valid = 1'b1;
      a = 16'ha5c0 + i[15:0];
      b = 16'h5a3f - i[15:0];
    end
    @(negedge clk);
    a = 16'hffff;
    b = 16'h0000;
    repeat (3) begin
      @(negedge clk);
      check("ready full", ready, 0);
    end
    // the ninth word stays offered until the first pop frees a slot
    run = 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (ready !== 1'b1 && n < 40);
    check("ready after pop", ready, 1);
    @(negedge clk);
    valid = 1'b0;
    for (int i = 0; i < 9; i++) begin
      get_word;
      exp_w = (i < 8) ? {16'ha5c0 + i[15:0], 16'h5a3f - i[15:0]} : 32'hffff_0000;
      check("word", {ra, rb}, exp_w);
      check("underrun", under, i == 8);
    end
    get_word;
    check("repeat", {ra, rb}, 32'hffff_0000);
  endtask : t_stream
  // forwarded clock period and high time follow the 160 ns sampling clock
  task automatic t_rate;
    realtime t0;
    @(posedge fclk);
    t0 = $realtime;
    @(negedge fclk);
    check("high time", int'($realtime - t0), 80);
    @(posedge fclk);
    check("period", int'($realtime - t0), 160);
  endtask : t_rate
  // reset in mid-stream: clock, pairs and underrun clear and ready is high, then the empty buffer sends zero words as underrun
  task automatic t_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    check("reset clock", fclk, 0);
    check("reset pairs", {pa, pb}, 0);
    check("reset underrun", under, 0);
    check("reset ready", ready, 1);
    rst = 1'b0;
    @(negedge clk);
    check("clock after release", fclk, 0);
    get_word;
    check("word after reset", {ra, rb}, 0);
    check("underrun after reset", under, 1);
  endtask : t_reset
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_stream;
    t_rate;
    t_reset;
    end_sim;
  end
  // watchdog: the scenarios need about 3 us, so 20 us means something hangs
  initial begin
    #20000;
    mismatches++;
    end_sim;
  end
endmodule : test_ddrop_port
`default_nettype wire
